// file: design/tpc_top.sv
// Timer counter with compare, edge-aligned and center-aligned PWM channels
module tpc_top
	import tpc_pkg::*;
#(
	parameter int NCH = 2
) (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           sys_rst,
	// Register port
	input  wire logic [7:0]     reg_addr,
	input  wire logic [7:0]     reg_wdata,
	input  wire logic           reg_wr,
	input  wire logic           reg_rd,
	output logic      [7:0]     reg_rdata,
	// Counter clock sources
	input  wire logic           fix_tick,
	input  wire logic           ext_clk_pin,
	// Channel pins
	input  wire logic [NCH-1:0] ch_pin_in,
	output logic      [NCH-1:0] ch_pin_out,
	output logic      [NCH-1:0] ch_pin_oe,
	// Interrupt
	output logic                irq
);
	import tpc_pkg::*;
`include "tpc_consts.svh"

	logic            tof_r, tof_nxt, tof_arm_r, tof_arm_nxt;
	logic            overflow_irq_enable_r, overflow_irq_enable_nxt, center_aligned_select_r, center_aligned_select_nxt;
	tpc_clk_sel_type clks_r, clks_nxt;
	logic [15:0]     cnt_r, cnt_nxt, mod_r, mod_nxt, modb_r, modb_nxt;
	logic            up_r, up_nxt, mhw_r, mhw_nxt, mlw_r, mlw_nxt;
	tpc_chsc_type    csc_r [NCH];
	tpc_chsc_type    csc_nxt [NCH];
	logic [15:0]     val_r [NCH];
	logic [15:0]     val_nxt [NCH];
	logic [15:0]     valb_r [NCH];
	logic [15:0]     valb_nxt [NCH];
	logic [NCH-1:0]  vhw_r, vhw_nxt, vlw_r, vlw_nxt, arm_r, arm_nxt;
	logic [NCH-1:0]  out_r, out_nxt, oe_r, oe_nxt;
	logic [7:0]      rdata_r, rdata_nxt;
	logic            irq_r, irq_nxt;
	logic            ext_s1_r, ext_s2_r, ext_s3_r;
	logic [NCH-1:0]  pin_s1_r, pin_s2_r, pin_s3_r;
	logic            tick, step, tsc_w, tsc_rd, cnt_wr, tof_ev, dn;
	logic [15:0]     term;
	logic [7:0]      ca;
	logic            m, cap, cmp, epwm, ev, edge_hit, load, sc_w;
	logic [NCH-1:0]  ch_ev, ie_v;

	// External clock is sampled on its rising edge after the synchroniser
	assign tick = (clks_r == TPC_CLK_BUS)
		| ((clks_r == TPC_CLK_FIX) & fix_tick)
		| ((clks_r == TPC_CLK_EXT) & ext_s2_r & !ext_s3_r);

	always_comb begin
		tsc_w     = reg_wr & (reg_addr == `TPC_SC_ADDR);
		tsc_rd    = reg_rd & (reg_addr == `TPC_SC_ADDR);
		cnt_wr    = reg_wr & ((reg_addr == `TPC_CNTH_ADDR) | (reg_addr == `TPC_CNTL_ADDR));
		step      = tick & !cnt_wr;
		term      = (mod_r == `TPC_WORD_RST) ? `TPC_CNT_FREE : mod_r;
		cnt_nxt   = cnt_r;
		up_nxt    = up_r;
		tof_ev    = 1'b0;
		overflow_irq_enable_nxt  = overflow_irq_enable_r;
		center_aligned_select_nxt = center_aligned_select_r;
		clks_nxt  = clks_r;
		mod_nxt   = mod_r;
		modb_nxt  = modb_r;
		mhw_nxt   = mhw_r;
		mlw_nxt   = mlw_r;
		tof_nxt   = tof_r;
		tof_arm_nxt = tof_arm_r;
		rdata_nxt = 8'h00;
		ch_ev     = '0;
		ie_v      = '0;
		ca = 8'h00;
		m = 1'b0;
		cap = 1'b0;
		cmp = 1'b0;
		epwm = 1'b0;
		ev = 1'b0;
		edge_hit = 1'b0;
		load = 1'b0;
		sc_w = 1'b0;

		// Main counter
		if (step) begin
			if (center_aligned_select_r) begin
				if (up_r) begin
					if (cnt_r == mod_r) begin
						up_nxt  = 1'b0;
						cnt_nxt = cnt_r - 16'h0001;
						tof_ev  = 1'b1;
					end else begin
						cnt_nxt = cnt_r + 16'h0001;
					end
				end else if (cnt_r == 16'h0000) begin
					up_nxt  = 1'b1;
					cnt_nxt = 16'h0001;
				end else begin
					cnt_nxt = cnt_r - 16'h0001;
				end
			end else begin
				up_nxt = 1'b1;
				if (cnt_r == term) begin
					cnt_nxt = 16'h0000;
					tof_ev  = 1'b1;
				end else begin
					cnt_nxt = cnt_r + 16'h0001;
				end
			end
		end
		if (cnt_wr) begin
			cnt_nxt = 16'h0000;
			up_nxt  = 1'b1;
		end
		dn = step & (cnt_nxt < cnt_r);

		// Timer status/control and overflow flag
		if (tsc_rd && tof_r) begin
			tof_arm_nxt = 1'b1;
		end
		if (tsc_w) begin
			overflow_irq_enable_nxt  = reg_wdata[`TPC_OVERFLOW_IRQ_ENABLE_BIT];
			center_aligned_select_nxt = reg_wdata[`TPC_CENTER_ALIGNED_SELECT_BIT];
			clks_nxt  = tpc_clk_sel_type'(reg_wdata[`TPC_CLKS_HI:`TPC_CLKS_LO]);
			mhw_nxt   = 1'b0;
			mlw_nxt   = 1'b0;
			tof_arm_nxt = 1'b0;
			if (tof_arm_r && !reg_wdata[`TPC_TOF_BIT]) begin
				tof_nxt = 1'b0;
			end
		end
		// The set wins over a clear in the same cycle
		if (tof_ev) begin
			tof_nxt     = 1'b1;
			tof_arm_nxt = 1'b0;
		end

		// Modulus goes through a byte buffer
		if (reg_wr && reg_addr == `TPC_MODH_ADDR) begin
			modb_nxt[15:8] = reg_wdata;
			mhw_nxt        = 1'b1;
		end
		if (reg_wr && reg_addr == `TPC_MODL_ADDR) begin
			modb_nxt[7:0] = reg_wdata;
			mlw_nxt       = 1'b1;
		end
		if ((mhw_r & mlw_r & tick) | ((clks_r == TPC_CLK_OFF) & mhw_nxt & mlw_nxt)) begin
			mod_nxt = modb_nxt;
			mhw_nxt = 1'b0;
			mlw_nxt = 1'b0;
		end

		case (reg_addr)
			`TPC_SC_ADDR:   rdata_nxt = {tof_r, overflow_irq_enable_r, center_aligned_select_r, clks_r, 3'b000};
			`TPC_CNTH_ADDR: rdata_nxt = cnt_r[15:8];
			`TPC_CNTL_ADDR: rdata_nxt = cnt_r[7:0];
			`TPC_MODH_ADDR: rdata_nxt = mod_r[15:8];
			`TPC_MODL_ADDR: rdata_nxt = mod_r[7:0];
			default:        rdata_nxt = 8'h00;
		endcase

		for (int i = 0; i < NCH; i++) begin
			ca          = 8'(`TPC_CH_BASE + `TPC_CH_STRIDE * i);
			csc_nxt[i]  = csc_r[i];
			val_nxt[i]  = val_r[i];
			valb_nxt[i] = valb_r[i];
			vhw_nxt[i]  = vhw_r[i];
			vlw_nxt[i]  = vlw_r[i];
			arm_nxt[i]  = arm_r[i];
			out_nxt[i]  = out_r[i];
			cap  = !center_aligned_select_r & !csc_r[i].msb & !csc_r[i].msa;
			cmp  = !center_aligned_select_r & !csc_r[i].msb & csc_r[i].msa;
			epwm = !center_aligned_select_r & csc_r[i].msb;
			sc_w = reg_wr & (reg_addr == ca + `TPC_CH_SC_OFS);
			m    = step & (cnt_nxt == val_r[i]);
			edge_hit = (csc_r[i].elsa & pin_s2_r[i] & !pin_s3_r[i])
				| (csc_r[i].elsb & !pin_s2_r[i] & pin_s3_r[i]);
			ev   = cap ? edge_hit : m;
			ch_ev[i] = ev;
			ie_v[i]  = csc_r[i].chie;

			// Channel value buffer; capture mode refuses writes
			if (!cap && reg_wr && reg_addr == ca + `TPC_CH_VH_OFS) begin
				valb_nxt[i][15:8] = reg_wdata;
				vhw_nxt[i]        = 1'b1;
			end
			if (!cap && reg_wr && reg_addr == ca + `TPC_CH_VL_OFS) begin
				valb_nxt[i][7:0] = reg_wdata;
				vlw_nxt[i]       = 1'b1;
			end
			if (cmp) begin
				load = vhw_r[i] & vlw_r[i] & step;
			end else begin
				// Only the upward step into the terminal count, not the way back down
				load = vhw_r[i] & vlw_r[i] & step & (cnt_r == term - 16'h0001)
					& (cnt_nxt == term);
			end
			if (clks_r == TPC_CLK_OFF) begin
				load = vhw_nxt[i] & vlw_nxt[i];
			end
			if (sc_w) begin
				csc_nxt[i].chie = reg_wdata[`TPC_CHIE_BIT];
				csc_nxt[i].msb  = reg_wdata[`TPC_MSB_BIT];
				csc_nxt[i].msa  = reg_wdata[`TPC_MSA_BIT];
				csc_nxt[i].elsb = reg_wdata[`TPC_ELSB_BIT];
				csc_nxt[i].elsa = reg_wdata[`TPC_ELSA_BIT];
				vhw_nxt[i] = 1'b0;
				vlw_nxt[i] = 1'b0;
				load       = 1'b0;
				arm_nxt[i] = 1'b0;
				if (arm_r[i] && !reg_wdata[`TPC_CHF_BIT]) begin
					csc_nxt[i].chf = 1'b0;
				end
			end
			if (load) begin
				val_nxt[i] = valb_nxt[i];
				vhw_nxt[i] = 1'b0;
				vlw_nxt[i] = 1'b0;
			end
			if (cap && edge_hit) begin
				val_nxt[i] = cnt_r;
			end
			if (reg_rd && reg_addr == ca + `TPC_CH_SC_OFS && csc_r[i].chf) begin
				arm_nxt[i] = 1'b1;
			end
			if (ev) begin
				csc_nxt[i].chf = 1'b1;
				arm_nxt[i]     = 1'b0;
			end

			// Pin behaviour per mode
			if (cap) begin
				out_nxt[i] = 1'b0;
			end else if (cmp) begin
				if (m) begin
					case ({csc_r[i].elsb, csc_r[i].elsa})
						2'b01:   out_nxt[i] = !out_r[i];
						2'b10:   out_nxt[i] = 1'b0;
						2'b11:   out_nxt[i] = 1'b1;
						default: out_nxt[i] = out_r[i];
					endcase
				end
			end else if (epwm) begin
				// Match after overflow so a zero value stays inactive
				if (tof_ev) begin
					out_nxt[i] = !csc_r[i].elsa;
				end
				if (m) begin
					out_nxt[i] = csc_r[i].elsa;
				end
			end else if (val_r[i] == 16'h0000 || val_r[i][15]) begin
				out_nxt[i] = csc_r[i].elsa;
			end else if (val_r[i] > mod_r) begin
				out_nxt[i] = !csc_r[i].elsa;
			end else if (m) begin
				out_nxt[i] = dn ^ csc_r[i].elsa;
			end
			oe_nxt[i] = !cap & (csc_r[i].elsb | csc_r[i].elsa);

			if (reg_addr == ca + `TPC_CH_SC_OFS) begin
				rdata_nxt = {csc_r[i], 2'b00};
			end else if (reg_addr == ca + `TPC_CH_VH_OFS) begin
				rdata_nxt = val_r[i][15:8];
			end else if (reg_addr == ca + `TPC_CH_VL_OFS) begin
				rdata_nxt = val_r[i][7:0];
			end
		end
		if (!reg_rd) begin
			rdata_nxt = 8'h00;
		end
		irq_nxt = (tof_nxt & overflow_irq_enable_nxt);
		for (int i = 0; i < NCH; i++) begin
			irq_nxt = irq_nxt | (csc_nxt[i].chf & csc_nxt[i].chie);
		end
	end

	always_ff @(posedge clk) begin
		ext_s1_r <= ext_clk_pin;
		ext_s2_r <= ext_s1_r;
		ext_s3_r <= ext_s2_r;
		pin_s1_r <= ch_pin_in;
		pin_s2_r <= pin_s1_r;
		pin_s3_r <= pin_s2_r;
		if (sys_rst) begin
			tof_r     <= 1'b0;
			tof_arm_r <= 1'b0;
			overflow_irq_enable_r    <= 1'b0;
			center_aligned_select_r   <= 1'b0;
			clks_r    <= TPC_CLK_OFF;
			cnt_r     <= `TPC_WORD_RST;
			mod_r     <= `TPC_WORD_RST;
			modb_r    <= `TPC_WORD_RST;
			up_r      <= 1'b1;
			mhw_r     <= 1'b0;
			mlw_r     <= 1'b0;
			vhw_r     <= '0;
			vlw_r     <= '0;
			arm_r     <= '0;
			out_r     <= '0;
			oe_r      <= '0;
			rdata_r   <= 8'h00;
			irq_r     <= 1'b0;
			for (int i = 0; i < NCH; i++) begin
				csc_r[i]  <= `TPC_CHSC_RST;
				val_r[i]  <= `TPC_WORD_RST;
				valb_r[i] <= `TPC_WORD_RST;
			end
		end else begin
			tof_r     <= tof_nxt;
			tof_arm_r <= tof_arm_nxt;
			overflow_irq_enable_r    <= overflow_irq_enable_nxt;
			center_aligned_select_r   <= center_aligned_select_nxt;
			clks_r    <= clks_nxt;
			cnt_r     <= cnt_nxt;
			mod_r     <= mod_nxt;
			modb_r    <= modb_nxt;
			up_r      <= up_nxt;
			mhw_r     <= mhw_nxt;
			mlw_r     <= mlw_nxt;
			vhw_r     <= vhw_nxt;
			vlw_r     <= vlw_nxt;
			arm_r     <= arm_nxt;
			out_r     <= out_nxt;
			oe_r      <= oe_nxt;
			rdata_r   <= rdata_nxt;
			irq_r     <= irq_nxt;
			csc_r     <= csc_nxt;
			val_r     <= val_nxt;
			valb_r    <= valb_nxt;
		end
	end

	assign reg_rdata  = rdata_r;
	assign ch_pin_out = out_r;
	assign ch_pin_oe  = oe_r;
	assign irq        = irq_r;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	ovf_set_a: assert property (tof_ev |=> tof_r)
		else $error("overflow flag not set");
	flag_keep_a: assert property (tof_r && !tsc_w |=> tof_r)
		else $error("overflow flag lost without clear write");
	cen_turn_a: assert property (center_aligned_select_r && up_r && step && cnt_r == mod_r
		|=> tof_r && !up_r && cnt_r == $past(mod_r) - 16'h0001)
		else $error("center turn at modulus wrong");
	up_wrap_a: assert property (!center_aligned_select_r && step && cnt_r == term |=> cnt_r == 16'h0000)
		else $error("counter did not wrap at terminal");
	mod_cancel_a: assert property (tsc_w |=> !mhw_r && !mlw_r)
		else $error("modulus buffer not cancelled");
	ch_cancel_a: assert property (reg_wr && reg_addr == `TPC_CH_BASE
		|=> !vhw_r[0] && !vlw_r[0])
		else $error("channel buffer not cancelled");
	ch_flag_a: assert property (ch_ev[0] |=> csc_r[0].chf)
		else $error("channel event flag not set");
	cen_zero_a: assert property (center_aligned_select_r && val_r[0][15] && !csc_r[0].elsa && !reg_wr
		|=> !ch_pin_out[0])
		else $error("negative value must give 0 percent");
	irq_gate_a: assert property (!overflow_irq_enable_r && ie_v == '0 && !reg_wr |=> !irq)
		else $error("interrupt not gated");
	cmp_off_a: assert property (clks_r == TPC_CLK_OFF && reg_wr && vhw_r[0]
		&& (center_aligned_select_r || csc_r[0].msb || csc_r[0].msa)
		&& reg_addr == `TPC_CH_BASE + `TPC_CH_VL_OFS
		|=> val_r[0] == {$past(valb_r[0][15:8]), $past(reg_wdata)})
		else $error("value not applied on second byte");
endmodule

// file: pkg/tpc_consts.svh
// Register offsets, field positions and reset values of the timer channel block
`ifndef TPC_CONSTS_SVH
`define TPC_CONSTS_SVH
`define TPC_SC_ADDR     8'h00
`define TPC_CNTH_ADDR   8'h01
`define TPC_CNTL_ADDR   8'h02
`define TPC_MODH_ADDR   8'h03
`define TPC_MODL_ADDR   8'h04
`define TPC_CH_BASE     8'h05
`define TPC_CH_STRIDE   8'h03
`define TPC_CH_SC_OFS   8'h00
`define TPC_CH_VH_OFS   8'h01
`define TPC_CH_VL_OFS   8'h02
`define TPC_TOF_BIT     7
`define TPC_OVERFLOW_IRQ_ENABLE_BIT    6
`define TPC_CENTER_ALIGNED_SELECT_BIT   5
`define TPC_CLKS_HI     4
`define TPC_CLKS_LO     3
`define TPC_CHF_BIT     7
`define TPC_CHIE_BIT    6
`define TPC_MSB_BIT     5
`define TPC_MSA_BIT     4
`define TPC_ELSB_BIT    3
`define TPC_ELSA_BIT    2
`define TPC_CHSC_RST    6'h00
`define TPC_WORD_RST    16'h0000
`define TPC_CNT_FREE    16'hffff
`endif

// file: pkg/tpc_pkg.sv
// Types shared by the timer channel block
package tpc_pkg;
	typedef enum logic [1:0] {
		TPC_CLK_OFF = 2'b00,
		TPC_CLK_BUS = 2'b01,
		TPC_CLK_FIX = 2'b10,
		TPC_CLK_EXT = 2'b11
	} tpc_clk_sel_type;
	typedef struct packed {
		logic chf;
		logic chie;
		logic msb;
		logic msa;
		logic elsb;
		logic elsa;
	} tpc_chsc_type;
endpackage

// file: tb/tb_top.sv
// Self-checking bench for the timer channel block
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
	$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic       fix_tick = 1'b0;
	logic       ext_clk_pin = 1'b0;
	logic [1:0] pin_lvl;
	logic [1:0] ch_pin_out;
	logic [1:0] ch_pin_oe;
	logic       irq;
	logic [1:0] drv_en = 2'b00;
	logic [1:0] drv_lvl = 2'b00;
	int         err_total = 0;
	int         n_checks = 0;
	always #2 clk = ~clk;
	tpc_top #(.NCH(2)) i_tpc_top (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fix_tick(fix_tick),
		.ext_clk_pin(ext_clk_pin), .ch_pin_in(pin_lvl), .ch_pin_out(ch_pin_out),
		.ch_pin_oe(ch_pin_oe), .irq(irq)
	);
	tpc_load_model #(.NCH(2)) i_tpc_load_model (
		.pin_out(ch_pin_out), .pin_oe(ch_pin_oe), .drv_en(drv_en), .drv_lvl(drv_lvl),
		.pin_lvl(pin_lvl)
	);
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		`CHK(d, exp)
	endtask
	// Program channel 0, let the value load, then count high cycles over 40
	task automatic pwm_case(input logic [7:0] sc, input logic [15:0] val,
			input logic [7:0] exp);
		logic [7:0] cnt;
		cnt = 8'h00;
		wr(8'h05, sc);
		wr(8'h06, val[15:8]);
		wr(8'h07, val[7:0]);
		repeat (24) @(posedge clk);
		repeat (40) begin
			@(negedge clk);
			cnt = cnt + {7'h00, pin_lvl[0]};
		end
		`CHK(cnt, exp)
	endtask
	task automatic reset_check;
		rd_chk(8'h00, 8'h00);
		rd_chk(8'h05, 8'h00);
		rd_chk(8'h04, 8'h00);
		`CHK(ch_pin_oe, 2'b00)
		`CHK(irq, 1'b0)
	endtask
	task automatic clk_select;
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h10);
		repeat (4) @(posedge clk);
		rd_chk(8'h02, 8'h00);
		repeat (3) begin
			@(posedge clk);
			fix_tick <= 1'b1;
			@(posedge clk);
			fix_tick <= 1'b0;
		end
		rd_chk(8'h02, 8'h03);
		wr(8'h00, 8'h18);
		repeat (2) begin
			repeat (8) @(posedge clk);
			ext_clk_pin <= 1'b1;
			repeat (8) @(posedge clk);
			ext_clk_pin <= 1'b0;
		end
		repeat (8) @(posedge clk);
		rd_chk(8'h02, 8'h05);
		wr(8'h00, 8'h00);
		repeat (6) @(posedge clk);
		rd_chk(8'h02, 8'h05);
	endtask
	// Modulus 3 gives a four-cycle period
	task automatic edge_pwm;
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h03);
		// A count left above the modulus would first run all the way to 0xffff
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h08);
		pwm_case(8'h28, 16'h0001, 8'd10);
		pwm_case(8'h2c, 16'h0001, 8'd30);
		pwm_case(8'h28, 16'h0000, 8'd0);
		pwm_case(8'h28, 16'h0005, 8'd40);
	endtask
	task automatic compare;
		logic p;
		wr(8'h00, 8'h00);
		wr(8'h01, 8'h00);
		wr(8'h08, 8'h54);
		wr(8'h09, 8'h00);
		wr(8'h0a, 8'h02);
		rd_chk(8'h0a, 8'h02);
		wr(8'h00, 8'h08);
		repeat (6) @(negedge clk);
		p = pin_lvl[1];
		repeat (4) @(negedge clk);
		`CHK(pin_lvl[1], ~p)
		`CHK(irq, 1'b1)
		rd_chk(8'h08, 8'hd4);
		wr(8'h08, 8'hdc);
		repeat (8) @(negedge clk);
		`CHK(pin_lvl[1], 1'b1)
		wr(8'h08, 8'hd8);
		repeat (8) @(negedge clk);
		`CHK(pin_lvl[1], 1'b0)
		wr(8'h08, 8'h80);
		@(negedge clk);
		`CHK(irq, 1'b0)
	endtask
	task automatic overflow;
		wr(8'h00, 8'h48);
		repeat (8) @(negedge clk);
		`CHK(irq, 1'b1)
		wr(8'h00, 8'h40);
		rd_chk(8'h00, 8'hc0);
		wr(8'h00, 8'h40);
		rd_chk(8'h00, 8'h40);
		`CHK(irq, 1'b0)
		wr(8'h00, 8'h00);
	endtask
	task automatic buf_cancel;
		wr(8'h03, 8'h12);
		wr(8'h00, 8'h00);
		wr(8'h04, 8'h34);
		rd_chk(8'h03, 8'h00);
		rd_chk(8'h04, 8'h03);
		wr(8'h06, 8'h11);
		wr(8'h05, 8'h28);
		wr(8'h07, 8'h22);
		rd_chk(8'h06, 8'h00);
		rd_chk(8'h07, 8'h05);
		wr(8'h06, 8'h00);
		rd_chk(8'h07, 8'h22);
		wr(8'h06, 8'h00);
		wr(8'h07, 8'h09);
		rd_chk(8'h07, 8'h09);
	endtask
	task automatic capture;
		logic [7:0] d;
		wr(8'h00, 8'h08);
		rd(8'h05, d);
		wr(8'h05, 8'h04);
		rd_chk(8'h05, 8'h04);
		`CHK(ch_pin_oe[0], 1'b0)
		drv_en <= 2'b01;
		repeat (6) @(posedge clk);
		drv_lvl <= 2'b01;
		repeat (6) @(posedge clk);
		rd_chk(8'h05, 8'h84);
		drv_en <= 2'b00;
	endtask
	// Modulus 4 in range and channel 1 idle, as center mode requires of software
	task automatic center;
		logic [7:0] d;
		wr(8'h00, 8'h00);
		wr(8'h03, 8'h00);
		wr(8'h04, 8'h04);
		wr(8'h08, 8'h00);
		wr(8'h01, 8'h00);
		wr(8'h00, 8'h28);
		pwm_case(8'h08, 16'h0001, 8'd10);
		pwm_case(8'h0c, 16'h0001, 8'd30);
		pwm_case(8'h08, 16'h0000, 8'd0);
		pwm_case(8'h08, 16'h8001, 8'd0);
		pwm_case(8'h08, 16'h0005, 8'd40);
		rd(8'h00, d);
		`CHK(d[7], 1'b1)
	endtask
	task automatic summarize;
		if (err_total == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		summarize();
	end
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		reset_check();
		clk_select();
		edge_pwm();
		compare();
		overflow();
		buf_cancel();
		capture();
		center();
		summarize();
	end
endmodule

// file: tb/tpc_load_model.sv
// Load on the channel pins: resolves each pin and feeds its level back
module tpc_load_model #(
	parameter int NCH = 2
) (
	// Block side
	input  wire logic [NCH-1:0] pin_out,
	input  wire logic [NCH-1:0] pin_oe,
	// Far-side driver
	input  wire logic [NCH-1:0] drv_en,
	input  wire logic [NCH-1:0] drv_lvl,
	// Resolved level
	output logic      [NCH-1:0] pin_lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	// Released pins show the far-side drive if drv_en is set, else a pull-up, so a stale pin_out never shows
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			pin_lvl[i] = pin_oe[i] ? pin_out[i] : (drv_en[i] ? drv_lvl[i] : 1'b1);
		end
	end
endmodule
